// ---- csp_defs.svh ----
// constants for the clock synthesizer two-wire control port
// assumes inclusion by bare name from the package and design files
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH

// 7-bit slave address, 8'hD2 with the write bit appended
`define CSP_SLAVE_ADDR    7'h69
// number of control registers held here
`define CSP_NUM_REGS      3
// command code bit that picks single-byte access
`define CSP_CMD_BYTE_BIT  7
// bits per byte on the wire
`define CSP_BYTE_BITS     4'h8

// power-up values of the three control registers
`define CSP_REG0_RST      8'hFF
`define CSP_REG1_RST      8'hF6
`define CSP_REG2_RST      8'hFF

// field positions in register byte 1
`define CSP_R1_FRB0_BIT   7
`define CSP_R1_VID_BIT    6
`define CSP_R1_USB_BIT    5
`define CSP_R1_REF_BIT    4
`define CSP_R1_SPREAD_BIT 0

`endif

// ---- csp_pkg.sv ----
// types shared by the two-wire control port
// assumes csp_defs.svh is on the include path
`include "csp_defs.svh"

package csp_pkg;

   // receive or transmit phase of the serial slave
   typedef enum logic [2:0] {
      csp_idle, csp_rx, csp_rx_ack, csp_tx, csp_tx_ack
   } csp_phase_t;

   // meaning of the byte being received
   typedef enum logic [1:0] {
      csp_k_addr, csp_k_cmd, csp_k_count, csp_k_data
   } csp_kind_t;

   typedef logic [`CSP_NUM_REGS-1:0][7:0] csp_regs_t;

   // whole state of the serial port
   typedef struct packed {
      csp_phase_t phase;
      csp_kind_t  kind;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic       oe;
      logic       rw;
      logic       byte_mode;
      logic [6:0] ptr;
      csp_regs_t  regs;
   } csp_state_t;

   // output enables and spread control seen by the clock outputs
   typedef struct packed {
      logic       host2_or_serial_ref7_pair_en;
      logic [6:1] serial_ref_pair_en;
      logic       free_running_bus_clock_0_en;
      logic       video_96mhz_pair_en;
      logic       usb_48mhz_en;
      logic       ref_clock_en;
      logic [1:0] host_pair_en;
      logic       spread_en;
      logic [5:0] bus_clock_en;
      logic [2:1] free_running_bus_clock_en;
   } csp_ctrl_t;

endpackage : csp_pkg

// ---- csp_sync_edge.sv ----
// two-flop synchroniser with edge detection for a group of inputs
// assumes asynchronous inputs and a single system clock
module csp_sync_edge #(
   parameter int W = 3
) (
   input  wire logic         clk,    // system clock
   input  wire logic         reset,  // synchronous, active high
   input  wire logic [W-1:0] din,    // raw asynchronous inputs
   output logic      [W-1:0] lvl,    // synchronised level
   output logic      [W-1:0] rise,   // one-cycle rising pulse
   output logic      [W-1:0] fall    // one-cycle falling pulse
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
      logic [W-1:0] prev;
   } csp_sync_state_t;

   csp_sync_state_t q;
   csp_sync_state_t d;

   // next state: meta feeds only sync
   always_comb begin
      d      = q;
      d.meta = din;
      d.sync = q.meta;
      d.prev = q.sync;
   end

   // idle bus level is high
   always_ff @(posedge clk) begin
      if (reset) begin
         q <= '{meta: '1, sync: '1, prev: '1};
      end else begin
         q <= d;
      end
   end

   // edges compare the two settled stages
   assign lvl  = q.sync;
   assign rise = q.sync & ~q.prev;
   assign fall = ~q.sync & q.prev;

endmodule : csp_sync_edge

// ---- csp_serial_port.sv ----
// two-wire serial slave port and control registers 0..2 of a clock synthesizer
// assumes scl and sda arrive asynchronously; the bench resolves the open-drain wire
`include "csp_defs.svh"

module csp_serial_port
   import csp_pkg::*;
(
   input  wire logic       clk,                // system clock, 25 MHz
   input  wire logic       reset,              // synchronous, active high
   input  wire logic       scl_in,             // serial clock from controller
   input  wire logic       sda_in,             // serial data wire level
   output logic            sda_out,            // data drive value, always low
   output logic            sda_oe,             // high while pulling data low
   input  wire logic       byte_count_skip_en, // block write sends no count
   output csp_pkg::csp_ctrl_t ctrl             // clock output controls
);
   import csp_pkg::*;

   localparam logic [6:0] NUM_REGS = 7'(`CSP_NUM_REGS);

   logic [2:0] s_lvl;
   logic [2:0] s_rise;
   logic [2:0] s_fall;
   logic       scl_rise;
   logic       scl_fall;
   logic       sda_lvl;
   logic       skip_en;
   logic       start_ev;
   logic       stop_ev;
   logic [7:0] rd_byte;
   logic [7:0] tx;

   csp_state_t q;
   csp_state_t d;

   // all pins pass two flops before use
   csp_sync_edge #(.W(3)) u_sync (
      .clk   (clk),
      .reset (reset),
      .din   ({byte_count_skip_en, sda_in, scl_in}),
      .lvl   (s_lvl),
      .rise  (s_rise),
      .fall  (s_fall)
   );

   // bus conditions from synchronised pins
   assign scl_rise = s_rise[0];
   assign scl_fall = s_fall[0];
   assign sda_lvl  = s_lvl[1];
   assign skip_en  = s_lvl[2];
   assign start_ev = s_lvl[0] & s_fall[1];
   assign stop_ev  = s_lvl[0] & s_rise[1];

   // read data, zero beyond the held registers
   assign rd_byte = (q.ptr < NUM_REGS) ? q.regs[q.ptr[1:0]] : 8'h00;

   // protocol engine
   always_comb begin
      d  = q;
      tx = 8'h00;
      if (start_ev) begin
         d.phase  = csp_rx;
         d.kind   = csp_k_addr;
         d.bitcnt = 4'h0;
         d.oe     = 1'b0;
      end else if (stop_ev) begin
         d.phase  = csp_idle;
         d.oe     = 1'b0;
      end else begin
         unique case (q.phase)
            csp_idle: begin
               d.oe = 1'b0;
            end
            csp_rx: begin
               if (scl_rise) begin
                  d.shreg  = {q.shreg[6:0], sda_lvl};
                  d.bitcnt = q.bitcnt + 4'h1;
               end else if (scl_fall && q.bitcnt == `CSP_BYTE_BITS) begin
                  d.bitcnt = 4'h0;
                  d.phase  = csp_rx_ack;
                  d.oe     = 1'b1;
                  unique case (q.kind)
                     csp_k_addr: begin
                        if (q.shreg[7:1] == `CSP_SLAVE_ADDR) begin
                           d.rw = q.shreg[0];
                        end else begin
                           d.phase = csp_idle;
                           d.oe    = 1'b0;
                        end
                     end
                     csp_k_cmd: begin
                        d.byte_mode = q.shreg[`CSP_CMD_BYTE_BIT];
                        d.ptr = q.shreg[`CSP_CMD_BYTE_BIT] ? q.shreg[6:0] : 7'h00;
                     end
                     csp_k_count: begin
                        d.ptr = q.ptr;                        // count not used
                     end
                     csp_k_data: begin
                        if (q.ptr < NUM_REGS) begin
                           d.regs[q.ptr[1:0]] = q.shreg;
                        end
                        d.ptr = q.ptr + 7'h01;
                     end
                  endcase
               end
            end
            csp_rx_ack: begin
               if (scl_fall) begin
                  d.oe = 1'b0;
                  if (q.kind == csp_k_addr && q.rw) begin
                     // read address: count for block, register for byte
                     tx = q.byte_mode ? rd_byte : {1'b0, NUM_REGS};
                     if (q.byte_mode) begin
                        d.ptr = q.ptr + 7'h01;
                     end
                     d.shreg  = tx;
                     d.oe     = ~tx[7];
                     d.bitcnt = 4'h0;
                     d.phase  = csp_tx;
                  end else begin
                     d.phase = csp_rx;
                     unique case (q.kind)
                        csp_k_addr:  d.kind = csp_k_cmd;
                        csp_k_cmd:   d.kind = (q.byte_mode || skip_en) ? csp_k_data
                                                                         : csp_k_count;
                        csp_k_count: d.kind = csp_k_data;
                        csp_k_data:  d.kind = csp_k_data;
                     endcase
                  end
               end
            end
            csp_tx: begin
               if (scl_rise) begin
                  d.bitcnt = q.bitcnt + 4'h1;
               end else if (scl_fall) begin
                  if (q.bitcnt == `CSP_BYTE_BITS) begin
                     d.oe    = 1'b0;
                     d.phase = csp_tx_ack;
                  end else begin
                     d.shreg = {q.shreg[6:0], 1'b0};
                     d.oe    = ~q.shreg[6];
                  end
               end
            end
            csp_tx_ack: begin
               if (scl_rise && sda_lvl) begin
                  d.phase = csp_idle;
               end else if (scl_fall) begin
                  tx       = rd_byte;
                  d.ptr    = q.ptr + 7'h01;
                  d.shreg  = tx;
                  d.oe     = ~tx[7];
                  d.bitcnt = 4'h0;
                  d.phase  = csp_tx;
               end
            end
         endcase
      end
   end

   // state register, defaults loaded at reset
   always_ff @(posedge clk) begin
      if (reset) begin
         q <= '{phase: csp_idle, kind: csp_k_addr, bitcnt: 4'h0, shreg: 8'h00,
                oe: 1'b0, rw: 1'b0, byte_mode: 1'b0, ptr: 7'h00,
                regs: {`CSP_REG2_RST, `CSP_REG1_RST, `CSP_REG0_RST}};
      end else begin
         q <= d;
      end
   end

   // open-drain data pin: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe  = q.oe;

   // control outputs straight from the registers
   always_comb begin
      ctrl.host2_or_serial_ref7_pair_en = q.regs[0][7];
      ctrl.serial_ref_pair_en           = q.regs[0][6:1];
      ctrl.free_running_bus_clock_0_en  = q.regs[1][`CSP_R1_FRB0_BIT];
      ctrl.video_96mhz_pair_en          = q.regs[1][`CSP_R1_VID_BIT];
      ctrl.usb_48mhz_en                 = q.regs[1][`CSP_R1_USB_BIT];
      ctrl.ref_clock_en                 = q.regs[1][`CSP_R1_REF_BIT];
      ctrl.host_pair_en                 = q.regs[1][2:1];
      ctrl.spread_en                    = q.regs[1][`CSP_R1_SPREAD_BIT];
      ctrl.bus_clock_en                 = q.regs[2][7:2];
      ctrl.free_running_bus_clock_en    = q.regs[2][1:0];
   end

   // checks on the protocol engine
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // own address answered with an acknowledge
   property p_addr_ack;
      (q.phase == csp_rx && q.kind == csp_k_addr && !start_ev && !stop_ev && scl_fall
       && q.bitcnt == `CSP_BYTE_BITS && q.shreg[7:1] == `CSP_SLAVE_ADDR)
      |=> (sda_oe && q.phase == csp_rx_ack);
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");

   // foreign address leaves the wire released
   property p_foreign;
      (q.phase == csp_rx && q.kind == csp_k_addr && !start_ev && !stop_ev && scl_fall
       && q.bitcnt == `CSP_BYTE_BITS && q.shreg[7:1] != `CSP_SLAVE_ADDR)
      |=> (!sda_oe && q.phase == csp_idle) [*2];
   endproperty
   a_foreign: assert property (p_foreign) else $error("foreign address acked");

   // byte command loads the offset
   property p_cmd_offset;
      (q.phase == csp_rx && q.kind == csp_k_cmd && !start_ev && !stop_ev && scl_fall
       && q.bitcnt == `CSP_BYTE_BITS && q.shreg[7])
      |=> (q.byte_mode && q.ptr == $past(q.shreg[6:0]));
   endproperty
   a_cmd_offset: assert property (p_cmd_offset) else $error("byte offset wrong");

   // block command count skipped only when enabled
   property p_skip;
      (q.phase == csp_rx_ack && q.kind == csp_k_cmd && !start_ev && !stop_ev && scl_fall
       && !q.byte_mode)
      |=> (q.kind == ($past(skip_en) ? csp_k_data : csp_k_count));
   endproperty
   a_skip: assert property (p_skip) else $error("count phase choice wrong");

   // data byte lands in the addressed register
   property p_write;
      (q.phase == csp_rx && q.kind == csp_k_data && !start_ev && !stop_ev && scl_fall
       && q.bitcnt == `CSP_BYTE_BITS && q.ptr < NUM_REGS)
      |=> (q.regs[$past(q.ptr[1:0])] == $past(q.shreg) && q.ptr == $past(q.ptr) + 7'h01);
   endproperty
   a_write: assert property (p_write) else $error("register write lost");

   // block read opens with the byte count
   property p_count;
      (q.phase == csp_rx_ack && q.kind == csp_k_addr && q.rw && !q.byte_mode
       && !start_ev && !stop_ev && scl_fall)
      |=> (q.phase == csp_tx && q.shreg == {1'b0, NUM_REGS});
   endproperty
   a_count: assert property (p_count) else $error("byte count not sent");

   // transmitted bit follows the shifter msb
   property p_msb;
      (q.phase == csp_tx && scl_rise) |-> (sda_oe == !q.shreg[7]);
   endproperty
   a_msb: assert property (p_msb) else $error("tx bit order wrong");

   // not-acknowledge ends transmission
   property p_nack;
      (q.phase == csp_tx_ack && scl_rise && sda_lvl && !start_ev && !stop_ev)
      |=> (!sda_oe && q.phase == csp_idle);
   endproperty
   a_nack: assert property (p_nack) else $error("nack ignored");

   // defaults present right after reset
   property p_defaults;
      @(posedge clk) disable iff (1'b0)
      $fell(reset) |-> (q.regs == {`CSP_REG2_RST, `CSP_REG1_RST, `CSP_REG0_RST});
   endproperty
   a_defaults: assert property (p_defaults) else $error("register defaults wrong");

   // idle engine never pulls the data wire
   property p_idle_release;
      (q.phase == csp_idle) |-> !sda_oe;
   endproperty
   a_idle_release: assert property (p_idle_release) else $error("idle drives data");

   // start always restarts address reception
   property p_start;
      start_ev
      |=> (q.phase == csp_rx && q.kind == csp_k_addr && q.bitcnt == 4'h0 && !sda_oe);
   endproperty
   a_start: assert property (p_start) else $error("start not taken");

   // stop always returns to idle with the wire released
   property p_stop;
      stop_ev |=> (q.phase == csp_idle && !sda_oe);
   endproperty
   a_stop: assert property (p_stop) else $error("stop not taken");

   // acknowledge released at the next clock fall on writes
   property p_ack_release;
      (q.phase == csp_rx_ack && scl_fall && !start_ev && !stop_ev
       && !(q.kind == csp_k_addr && q.rw))
      |=> (!sda_oe && q.phase == csp_rx);
   endproperty
   a_ack_release: assert property (p_ack_release) else $error("ack held too long");

   // received bits enter the shifter lsb side, msb first on the wire
   property p_rx_shift;
      (q.phase == csp_rx && scl_rise && !start_ev && !stop_ev)
      |=> (q.shreg == {$past(q.shreg[6:0]), $past(sda_lvl)}
           && q.bitcnt == $past(q.bitcnt) + 4'h1);
   endproperty
   a_rx_shift: assert property (p_rx_shift) else $error("rx bit lost");

   // wire released for the controller answer after eight bits
   property p_tx_release;
      (q.phase == csp_tx && scl_fall && q.bitcnt == `CSP_BYTE_BITS && !start_ev && !stop_ev)
      |=> (!sda_oe && q.phase == csp_tx_ack);
   endproperty
   a_tx_release: assert property (p_tx_release) else $error("tx not released");

   // acknowledged read moves on to the next offset
   property p_next_byte;
      (q.phase == csp_tx_ack && scl_fall && !start_ev && !stop_ev)
      |=> (q.phase == csp_tx && q.ptr == $past(q.ptr) + 7'h01 && sda_oe == !q.shreg[7]);
   endproperty
   a_next_byte: assert property (p_next_byte) else $error("next read byte wrong");

   // nothing is written while the engine ignores the bus
   property p_idle_regs;
      (q.phase == csp_idle) |=> (q.regs == $past(q.regs));
   endproperty
   a_idle_regs: assert property (p_idle_regs) else $error("register changed in idle");

   // bit counter never passes one byte
   property p_bitcnt;
      (q.phase == csp_rx || q.phase == csp_tx) |-> (q.bitcnt <= `CSP_BYTE_BITS);
   endproperty
   a_bitcnt: assert property (p_bitcnt) else $error("bit count overrun");

endmodule : csp_serial_port

// ---- csp_host_model.sv ----
// controller model for the two-wire control port: start, stop, bit and byte
// assumes the bench ands sda_h with the device drive into sda_w (pull-up)
module csp_host_model (
   input  wire logic clk,   // system clock
   input  wire logic sda_w, // resolved data wire
   output logic      scl,   // serial clock, idle high
   output logic      sda_h  // data drive, 1 = released
);
   timeunit 1ns;
   timeprecision 1ns;

   // bus idle, clock stands high between frames
   initial begin
      scl = 1'b1;
      sda_h = 1'b1;
   end

   // wait n falling edges
   task automatic w(input int n);
      repeat (n) @(negedge clk);
   endtask : w

   // start or repeated start, leaves scl low
   task automatic start;
      sda_h = 1'b1;
      w(4);
      scl = 1'b1;
      w(4);
      sda_h = 1'b0;
      w(4);
      scl = 1'b0;
   endtask : start

   // stop, data rises while scl high
   task automatic stop;
      w(1);
      sda_h = 1'b0;
      w(4);
      scl = 1'b1;
      w(4);
      sda_h = 1'b1;
      w(4);
   endtask : stop

   // one 320 ns bit: 6 clk low, 2 clk high, wire read in high phase
   task automatic xbit(input logic b, output logic r);
      w(1);
      sda_h = b;
      w(5);
      scl = 1'b1;
      w(1);
      r = sda_w;
      w(1);
      scl = 1'b0;
   endtask : xbit

   // byte out msb first, then the slave acknowledge
   task automatic send(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xbit(v[i], r);
      xbit(1'b1, r);
      ack = ~r;
   endtask : send

   // byte in msb first, the last one answered with not-acknowledge
   task automatic recv(input logic last, output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xbit(1'b1, r);
         v[i] = r;
      end
      xbit(last, r);
   endtask : recv
endmodule : csp_host_model

// ---- test_csp_serial_port.sv ----
// self-checking bench for csp_serial_port driven through the controller model
// assumes csp_pkg, csp_serial_port and csp_host_model are compiled first
module test_csp_serial_port;
   timeunit 1ns;
   timeprecision 1ns;
   import csp_pkg::*;

   logic            clk;
   logic            reset;
   logic            skip;
   logic            scl;
   logic            sda_h;
   logic            sda_out;
   logic            sda_oe;
   logic            sda_w;
   csp_ctrl_t       ctrl;
   logic [2:0][7:0] regs;                               // expected registers
   logic [2:0][7:0] vals = {8'hA5, 8'h0B, 8'h00};      // byte write values
   logic            ack;
   logic [7:0]      d;
   int              failures = 0;
   int              checks_done = 0;
   int              cycles = 0;

   // open-drain data wire with pull-up
   assign sda_w = sda_h & (sda_oe ? sda_out : 1'b1);

   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   csp_serial_port uut (
      .clk                (clk),
      .reset              (reset),
      .scl_in             (scl),
      .sda_in             (sda_w),
      .sda_out            (sda_out),
      .sda_oe             (sda_oe),
      .byte_count_skip_en (skip),
      .ctrl               (ctrl)
   );

   csp_host_model host (
      .clk   (clk),
      .sda_w (sda_w),
      .scl   (scl),
      .sda_h (sda_h)
   );

   // cut a hang short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         failures++;
         print_verdict();
      end
   end

   // compare and count
   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // send a byte and check the acknowledge
   task automatic snd(input logic [7:0] v, input logic e);
      host.send(v, ack);
      chk(24'(ack), 24'(e), "ack");
   endtask : snd

   // clock controls against the expected registers
   task automatic chk_ctrl;
      logic [23:0] e;
      e = {2'h0, regs[0][7:1], regs[1][7:4], regs[1][2:0], regs[2]};
      chk(24'(ctrl), e, "ctrl");
   endtask : chk_ctrl

   // hold reset 20 cycles, expect power-up values
   task automatic do_reset;
      reset = 1'b1;
      regs = {8'hFF, 8'hF6, 8'hFF};
      repeat (20) @(negedge clk);
      reset = 1'b0;
      repeat (4) @(negedge clk);
   endtask : do_reset

   task automatic byte_write(input logic [6:0] off, input logic [7:0] v);
      host.start();
      snd(8'hD2, 1'b1);
      snd({1'b1, off}, 1'b1);
      snd(v, 1'b1);
      host.stop();
      if (off < 7'h03) regs[off] = v;
   endtask : byte_write

   task automatic byte_read(input logic [6:0] off);
      host.start();
      snd(8'hD2, 1'b1);
      snd({1'b1, off}, 1'b1);
      host.start();
      snd(8'hD3, 1'b1);
      host.recv(1'b1, d);
      host.stop();
      chk(24'(d), (off < 7'h03) ? 24'(regs[off]) : 24'h0, "byte read");
   endtask : byte_read

   task automatic block_write(input int n, input logic [2:0][7:0] v, input logic s);
      skip = s;
      host.start();
      snd(8'hD2, 1'b1);
      snd(8'h00, 1'b1);
      if (!s) snd(8'(n), 1'b1);
      for (int i = 0; i < n; i++) begin
         snd(v[i], 1'b1);
         regs[i] = v[i];
      end
      host.stop();
      skip = 1'b0;
   endtask : block_write

   task automatic block_read(input int n);
      host.start();
      snd(8'hD2, 1'b1);
      snd(8'h00, 1'b1);
      host.start();
      snd(8'hD3, 1'b1);
      host.recv(1'b0, d);
      chk(24'(d), 24'h3, "count");
      for (int i = 0; i < n; i++) begin
         host.recv(i == n - 1, d);
         chk(24'(d), 24'(regs[i]), "block byte");
      end
      host.stop();
   endtask : block_read

   task automatic tdone(input string name);
      $display("test %s done at %0t", name, $time);
   endtask : tdone

   task automatic print_verdict;
      $display("checks %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict

   // main sequence
   initial begin
      skip = 1'b0;
      do_reset();
      chk_ctrl();
      block_read(3);
      tdone("defaults");
      for (int i = 0; i < 3; i++) byte_write(7'(i), vals[i]);
      chk_ctrl();
      for (int i = 0; i < 3; i++) byte_read(7'(i));
      byte_write(7'h05, 8'h12);
      byte_read(7'h05);
      chk_ctrl();
      tdone("byte access");
      block_write(3, {8'h3C, 8'h5A, 8'hC3}, 1'b0);
      chk_ctrl();
      block_read(3);
      tdone("block write");
      block_write(2, {8'h00, 8'h96, 8'h69}, 1'b1);
      block_read(2);
      byte_read(7'h02);
      chk_ctrl();
      tdone("count skip");
      host.start();
      snd(8'hD4, 1'b0);
      snd(8'h81, 1'b0);
      snd(8'h00, 1'b0);
      host.stop();
      chk_ctrl();
      tdone("foreign address");
      do_reset();
      chk_ctrl();
      byte_read(7'h01);
      tdone("second reset");
      print_verdict();
   end
endmodule : test_csp_serial_port
